/* rtl/fcc_core.sv */
// Digital control of one fast comparator channel with its reference DAC.
//-----------------------------------------------------------------------
// Operation
// RULE1: enable bit switches channel on or off
// RULE2: disabled channel powers down DAC and comparator
// RULE3: idle_stop halts channel during Idle
// RULE4: any idle_stop in group stops all
// RULE5: glitch filter drops pulses under two cycles
// RULE6: filter bypassed in Sleep or Idle
// RULE7: asynchronous event path wakes the processor; the code clocks wake_request through fcc_sync and a register instead
// RULE8: event pulse exactly one instruction cycle
// RULE9: source_select routes input A to D
// RULE10: external_ref_select picks external DAC reference
// RULE11: range bit picks half supply or internal
// RULE12: output_invert inverts comparator output
// RULE13: compare_state reads output after inversion
// RULE14: ref_out_enable connects DAC to pin
// RULE15: software sets ref_out_enable in one channel
// RULE16: unimplemented control bits read zero
// RULE17: implemented control bits reset to zero
// RULE18: filtered output feeds several consumers
// RULE19: ten-bit level field drives DAC code
// RULE20: comparator output synchronised before filter
//-----------------------------------------------------------------------
`timescale 1ns/1ps
`include "fcc_regs.svh"
module fcc_core #(
    parameter int LEVEL_W = 10
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Power mode of the processor.
    input wire fcc_pkg::fcc_mode_type power_mode,
    // Stop-in-Idle request gathered from the other channels.
    input wire logic group_idle_stop,
    // Raw comparator output from the analog core.
    input wire logic comp_raw,
    // Analog controls.
    output logic analog_power,
    output logic [1:0] source_select,
    output fcc_pkg::fcc_ref_type ref_source,
    output logic [LEVEL_W-1:0] ref_level,
    output logic ref_output_pin_en,
    // Own stop-in-Idle request, and consumers of the comparator result.
    output logic own_idle_stop,
    output logic comp_filtered,
    output logic event_pulse,
    output logic wake_request
);
    import fcc_pkg::*;

    //-------------------------------------------------------------------
    // Register file
    //-------------------------------------------------------------------
    logic [15:0] ctrl_reg; // Control word, only implemented bits held.
    logic [15:0] ctrl_next;
    logic [LEVEL_W-1:0] level_reg; // DAC input code.
    logic [LEVEL_W-1:0] level_next;
    logic [15:0] rdata_reg; // Read data, valid the cycle after strobe.
    logic [15:0] rdata_next;
    logic state_bit; // Polarity-corrected comparator state.
    logic filt_reg; // Filtered, polarity-corrected output.
    logic wake_reg; // Low-power wake request level.

    // Next values of the software-visible registers.
    always_comb begin
        ctrl_next = ctrl_reg;
        level_next = level_reg;
        rdata_next = 16'h0000;
        if (reg_wr && reg_addr == `FCC_ADDR_CONTROL) begin
            // Unimplemented and read-only bits drop the write.
            ctrl_next = reg_wdata & `FCC_CONTROL_MASK; // [RULE16]
        end
        if (reg_wr && reg_addr == `FCC_ADDR_LEVEL) begin
            level_next = reg_wdata[LEVEL_W-1:0]; // [RULE19]
        end
        if (reg_rd) begin
            case (reg_addr)
                `FCC_ADDR_CONTROL: begin
                    rdata_next = ctrl_reg; // [RULE16]
                    rdata_next[`FCC_BIT_STATE] = state_bit; // [RULE13]
                end
                `FCC_ADDR_LEVEL: begin
                    rdata_next = 16'(level_reg);
                end
                `FCC_ADDR_STATUS: begin
                    rdata_next = {13'h0000, wake_reg, filt_reg,
                        state_bit};
                end
                default: begin
                    // Unmapped addresses read as zero.
                    rdata_next = 16'h0000;
                end
            endcase
        end
    end

    // Register the software state; all bits clear at reset.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= `FCC_CONTROL_RESET; // [RULE17]
            level_reg <= `FCC_LEVEL_RESET; // [RULE17]
            rdata_reg <= 16'h0000;
        end else begin
            ctrl_reg <= ctrl_next;
            level_reg <= level_next;
            rdata_reg <= rdata_next;
        end
    end

    //-------------------------------------------------------------------
    // Run control
    //-------------------------------------------------------------------
    logic enabled;
    logic in_idle;
    logic in_low_power;
    logic running;

    // Idle stops the channel when this or any other channel asks for it.
    always_comb begin
        enabled = ctrl_reg[`FCC_BIT_ENABLE]; // [RULE1]
        in_idle = (power_mode == FCC_IDLE);
        in_low_power = (power_mode != FCC_RUN);
        running = enabled && !(in_idle && // [RULE3]
            (ctrl_reg[`FCC_BIT_IDLE_STOP] ||
            group_idle_stop)); // [RULE4]
    end

    //-------------------------------------------------------------------
    // Comparator path
    //-------------------------------------------------------------------
    logic comp_sync;

    // Raw output crosses into the clock domain before any use.
    fcc_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in(comp_raw),
        .sync_out(comp_sync)
    ); // [RULE20]

    assign state_bit = running &&
        (comp_sync ^ ctrl_reg[`FCC_BIT_INVERT]); // [RULE12]

    logic filt_next;
    logic cand_reg; // Candidate level under test.
    logic cand_next;
    logic [1:0] cnt_reg; // Cycles the candidate has held.
    logic [1:0] cnt_next;
    logic pulse_reg;
    logic pulse_next;
    logic wake_next;

    // A change is accepted only after it has held two whole cycles;
    // in Sleep or Idle the filter is skipped so a wake can pass at once.
    always_comb begin
        filt_next = filt_reg;
        cand_next = state_bit;
        cnt_next = cnt_reg;
        if (state_bit != cand_reg) begin
            cnt_next = 2'h1;
        end else if (cnt_reg < 2'(`FCC_FILTER_CYCLES)) begin
            cnt_next = cnt_reg + 2'h1;
        end
        if (in_low_power) begin
            filt_next = state_bit; // [RULE6]
        end else if (state_bit == cand_reg &&
            cnt_reg >= 2'(`FCC_FILTER_CYCLES - 1)) begin
            filt_next = state_bit; // [RULE5]
        end
        // Rising edge of the filtered output gives one-cycle pulse.
        pulse_next = filt_next && !filt_reg; // [RULE8]
        // Wake request while asleep, on an accepted event.
        wake_next = in_low_power && state_bit; // [RULE7]
    end

    // Register the filter, pulse and wake state.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            filt_reg <= 1'b0;
            cand_reg <= 1'b0;
            cnt_reg <= 2'h0;
            pulse_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            filt_reg <= filt_next;
            cand_reg <= cand_next;
            cnt_reg <= cnt_next;
            pulse_reg <= pulse_next;
            wake_reg <= wake_next;
        end
    end

    //-------------------------------------------------------------------
    // Analog control outputs
    //-------------------------------------------------------------------
    logic power_reg;
    logic [1:0] src_reg;
    fcc_ref_type refsrc_reg;
    fcc_ref_type refsrc_next;
    logic [LEVEL_W-1:0] lvl_out_reg;
    logic pin_reg;
    logic stop_reg;

    // Pick the DAC reference: external wins, else range bit decides.
    always_comb begin
        if (ctrl_reg[`FCC_BIT_EXT_REF]) begin
            refsrc_next = FCC_REF_EXTERNAL; // [RULE10]
        end else if (ctrl_reg[`FCC_BIT_RANGE]) begin
            refsrc_next = FCC_REF_HALF_SUPPLY; // [RULE11]
        end else begin
            refsrc_next = FCC_REF_INTERNAL; // [RULE11]
        end
    end

    // Analog settings are registered so the outputs stay glitch free.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            power_reg <= 1'b0;
            src_reg <= 2'h0;
            refsrc_reg <= FCC_REF_INTERNAL;
            lvl_out_reg <= `FCC_LEVEL_RESET;
            pin_reg <= 1'b0;
            stop_reg <= 1'b0;
        end else begin
            // Power covers both DAC and comparator together.
            power_reg <= running; // [RULE2]
            src_reg <= ctrl_reg[`FCC_BIT_SRC_HI:`FCC_BIT_SRC_LO]; // [RULE9]
            refsrc_reg <= refsrc_next;
            lvl_out_reg <= level_reg; // [RULE19]
            // Several channels driving the pin is software's fault.
            pin_reg <= ctrl_reg[`FCC_BIT_REF_OUT] && running; // [RULE14]
            stop_reg <= ctrl_reg[`FCC_BIT_IDLE_STOP];
        end
    end

    // Every output comes straight from a flip-flop; the filtered level
    // fans out to interrupt, ADC trigger and PWM logic alike.
    assign reg_rdata = rdata_reg;
    assign analog_power = power_reg;
    assign source_select = src_reg;
    assign ref_source = refsrc_reg;
    assign ref_level = lvl_out_reg;
    assign ref_output_pin_en = pin_reg;
    assign own_idle_stop = stop_reg;
    assign comp_filtered = filt_reg; // [RULE18]
    assign event_pulse = pulse_reg; // [RULE8]
    assign wake_request = wake_reg;

    //-------------------------------------------------------------------
    // Checks
    //-------------------------------------------------------------------
    // A trigger that stood two cycles would start two conversions.
    pulse_one_a: assert property ( // [RULE8]
        @(posedge clk) disable iff (!nrst)
        event_pulse |=> !event_pulse)
        else $error("event pulse longer than one cycle");
    // A disabled channel keeps DAC and comparator unpowered.
    power_off_a: assert property ( // [RULE2]
        @(posedge clk) disable iff (!nrst)
        !enabled |=> !analog_power)
        else $error("channel powered while disabled");
    // Another channel's stop request is obeyed in Idle.
    group_stop_a: assert property ( // [RULE4]
        @(posedge clk) disable iff (!nrst)
        (in_idle && group_idle_stop) |=> !analog_power)
        else $error("group idle stop ignored");
    // A fresh rise in run mode is never accepted at once.
    glitch_drop_a: assert property ( // [RULE5]
        @(posedge clk) disable iff (!nrst)
        (power_mode == FCC_RUN && $past(power_mode) == FCC_RUN &&
         state_bit && !cand_reg && !filt_reg)
        |=> !filt_reg)
        else $error("filter passed a one-cycle change");
    // Unimplemented control bits can never hold a one.
    reserved_zero_a: assert property ( // [RULE16]
        @(posedge clk) disable iff (!nrst)
        (ctrl_reg & ~`FCC_CONTROL_MASK) == 16'h0000)
        else $error("unimplemented control bit set");
    // The state bit read back is the inverted, running level.
    read_state_a: assert property ( // [RULE13]
        @(posedge clk) disable iff (!nrst)
        (reg_rd && reg_addr == `FCC_ADDR_CONTROL)
        |=> reg_rdata[`FCC_BIT_STATE] == $past(state_bit))
        else $error("compare state read wrong");
    // External reference overrides the range bit.
    ref_pick_a: assert property ( // [RULE10]
        @(posedge clk) disable iff (!nrst)
        ctrl_reg[`FCC_BIT_EXT_REF] |=> ref_source == FCC_REF_EXTERNAL)
        else $error("external reference not chosen");
    // In low power the filter follows the state one cycle later, unfiltered.
    bypass_low_a: assert property ( // [RULE6]
        @(posedge clk) disable iff (!nrst)
        in_low_power |=> filt_reg == $past(state_bit))
        else $error("filter not bypassed in low power");
    // Asleep, the wake level tracks the compare state.
    wake_level_a: assert property ( // [RULE7]
        @(posedge clk) disable iff (!nrst)
        in_low_power |=> wake_request == $past(state_bit))
        else $error("wake request missed in low power");
    // The input mux follows the select field one cycle later.
    source_route_a: assert property ( // [RULE9]
        @(posedge clk) disable iff (!nrst)
        source_select == $past(ctrl_reg[`FCC_BIT_SRC_HI:`FCC_BIT_SRC_LO]))
        else $error("input source not routed");
    // A stopped channel never drives the shared reference pin.
    pin_gate_a: assert property ( // [RULE14]
        @(posedge clk) disable iff (!nrst)
        !running |=> !ref_output_pin_en)
        else $error("reference pin driven while stopped");
endmodule : fcc_core

/* pkg/fcc_regs.svh */
// Register offsets, field positions and reset values of the comparator control.
`ifndef FCC_REGS_SVH
`define FCC_REGS_SVH
`define FCC_ADDR_CONTROL 4'h0
`define FCC_ADDR_LEVEL 4'h1
`define FCC_ADDR_STATUS 4'h2
`define FCC_BIT_ENABLE 15
`define FCC_BIT_IDLE_STOP 13
`define FCC_BIT_REF_OUT 8
`define FCC_BIT_SRC_HI 7
`define FCC_BIT_SRC_LO 6
`define FCC_BIT_EXT_REF 5
`define FCC_BIT_STATE 3
`define FCC_BIT_INVERT 1
`define FCC_BIT_RANGE 0
`define FCC_CONTROL_MASK 16'ha1e3
`define FCC_CONTROL_RESET 16'h0000
`define FCC_LEVEL_RESET 10'h000
`define FCC_FILTER_CYCLES 2
`endif

/* pkg/fcc_pkg.sv */
// Types shared by the comparator control block.
package fcc_pkg;
    // Reference source for the DAC.
    typedef enum logic [1:0] {
        FCC_REF_INTERNAL = 2'b00,
        FCC_REF_HALF_SUPPLY = 2'b01,
        FCC_REF_EXTERNAL = 2'b10
    } fcc_ref_type;
    // Power modes of the processor.
    typedef enum logic [1:0] {
        FCC_RUN = 2'b00,
        FCC_IDLE = 2'b01,
        FCC_SLEEP = 2'b10
    } fcc_mode_type;
endpackage : fcc_pkg

/* rtl/fcc_sync.sv */
// Three-stage synchroniser with agreement of the last two stages.
`timescale 1ns/1ps
module fcc_sync (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Asynchronous level in, clean level out.
    input wire logic async_in,
    output logic sync_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic out_reg;
    logic out_next;

    // The held level changes only once stage two and three agree.
    always_comb begin
        out_next = out_reg;
        if (s2_reg == s3_reg) begin
            out_next = s3_reg;
        end
    end

    // Registers only; stage one is read only by stage two.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;
endmodule : fcc_sync

/* sim/fcc_far_model.sv */
// Far-side consumer model: ADC trigger, interrupt and PWM fault logic.
`timescale 1ns/1ps
module fcc_far_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Comparator results.
    input wire logic event_pulse,
    input wire logic comp_filtered,
    // Observed counts.
    output int pulse_count,
    output int wide_count,
    output logic fault_latched
);
    logic last_pulse; // Pulse seen in the previous cycle.
    // Count triggers; a trigger held two cycles would fire twice.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_pulse <= 1'b0;
            pulse_count <= 0;
            wide_count <= 0;
            fault_latched <= 1'b0;
        end else begin
            last_pulse <= event_pulse;
            if (event_pulse) begin
                pulse_count <= pulse_count + 1;
            end
            if (event_pulse && last_pulse) begin
                wide_count <= wide_count + 1;
            end
            // The fault latch holds once the filtered level trips.
            if (comp_filtered) begin
                fault_latched <= 1'b1;
            end
        end
    end
endmodule : fcc_far_model

/* sim/tb_top.sv */
// Self-checking bench for the comparator control block.
`timescale 1ns/1ps
`include "fcc_regs.svh"
module tb_top;
    import fcc_pkg::*;
    logic clk, nrst, reg_wr, reg_rd, group_idle_stop, comp_raw;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_val, ctrl_m, d;
    fcc_mode_type power_mode;
    fcc_ref_type ref_source, ref_m;
    logic analog_power, ref_output_pin_en, own_idle_stop;
    logic comp_filtered, event_pulse, wake_request, fault_latched;
    logic [1:0] source_select;
    logic [9:0] ref_level;
    logic [31:0] seed; // Random source state.
    int pulse_count, wide_count, miscompares, checks_done;

    fcc_core fcc_core_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .power_mode(power_mode),
        .group_idle_stop(group_idle_stop), .comp_raw(comp_raw),
        .analog_power(analog_power), .source_select(source_select),
        .ref_source(ref_source), .ref_level(ref_level),
        .ref_output_pin_en(ref_output_pin_en),
        .own_idle_stop(own_idle_stop), .comp_filtered(comp_filtered),
        .event_pulse(event_pulse), .wake_request(wake_request));
    fcc_far_model fcc_far_model_inst (.clk(clk), .nrst(nrst),
        .event_pulse(event_pulse), .comp_filtered(comp_filtered),
        .pulse_count(pulse_count), .wide_count(wide_count),
        .fault_latched(fault_latched));

    // Next value of the 32-bit random sequence.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Compare a register read.
    task automatic chk_reg(input string n, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk_reg
    // Compare a port output.
    task automatic chk_out(input string n, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk_out
    // One-cycle write strobe.
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // One-cycle read strobe; data stand only in the next cycle.
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd
    // Let registered outputs land.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    // Print counts and verdict, then stop.
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // Clock of 100 ns period.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Watchdog well beyond the expected run of under two hundred cycles.
    initial begin
        #(100 * 3000);
        miscompares++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        nrst = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000;
        reg_wr = 1'b0; reg_rd = 1'b0; power_mode = FCC_RUN;
        group_idle_stop = 1'b0; comp_raw = 1'b0; seed = 32'h8fbf23bf;
        miscompares = 0; checks_done = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rd(`FCC_ADDR_CONTROL);
        chk_reg("control", 16'h0000, rd_val);
        rd(`FCC_ADDR_LEVEL);
        chk_reg("level", 16'h0000, rd_val);
        chk_out("power", 16'h0000, analog_power);
        $display("test reset done");
        // Random settings with every source and reference forced.
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            d = seed[15:0];
            d[7:6] = i[1:0];
            d[5] = i[2];
            d[0] = i[0];
            d[15] = (i != 3);
            ctrl_m = d & `FCC_CONTROL_MASK;
            ref_m = d[5] ? FCC_REF_EXTERNAL
                  : (d[0] ? FCC_REF_HALF_SUPPLY : FCC_REF_INTERNAL);
            wr(`FCC_ADDR_CONTROL, d);
            rd(`FCC_ADDR_CONTROL);
            chk_reg("control", ctrl_m, rd_val & 16'hfff7);
            chk_out("power", ctrl_m[15], analog_power);
            chk_out("source", ctrl_m[7:6], source_select);
            chk_out("ref", ref_m, ref_source);
            chk_out("pin", d[15] & d[8], ref_output_pin_en);
            chk_out("stop", ctrl_m[13], own_idle_stop);
            seed = lfsr(seed);
            wr(`FCC_ADDR_LEVEL, seed[15:0]);
            rd(`FCC_ADDR_LEVEL);
            chk_reg("level", seed[9:0], rd_val);
            chk_out("ref_level", seed[9:0], ref_level);
        end
        wr(4'h5, 16'hffff);
        rd(`FCC_ADDR_CONTROL);
        chk_reg("control", ctrl_m, rd_val & 16'hfff7);
        $display("test registers done");
        // Reset again so the far model counts only this test's events;
        // the random settings above may already have made pulses.
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(`FCC_ADDR_CONTROL);
        chk_reg("control", 16'h0000, rd_val);
        // A one-cycle blip must not pass; a held level must.
        wr(`FCC_ADDR_CONTROL, 16'h8000);
        settle(4);
        @(posedge clk);
        comp_raw <= 1'b1;
        @(posedge clk);
        comp_raw <= 1'b0;
        settle(10);
        chk_out("filtered", 16'h0000, comp_filtered);
        chk_out("pulses", 16'h0000, pulse_count[15:0]);
        comp_raw <= 1'b1;
        for (int k = 0; k < 12 && comp_filtered !== 1'b1; k++) settle(1);
        settle(4);
        chk_out("filtered", 16'h0001, comp_filtered);
        chk_out("pulses", 16'h0001, pulse_count[15:0]);
        chk_out("wide", 16'h0000, wide_count[15:0]);
        chk_out("fault", 16'h0001, fault_latched);
        rd(`FCC_ADDR_STATUS);
        chk_reg("status", 16'h0003, rd_val);
        wr(`FCC_ADDR_CONTROL, 16'h8002);
        settle(8);
        rd(`FCC_ADDR_CONTROL);
        chk_reg("control", 16'h8002, rd_val);
        $display("test filter done");
        // Idle stop, own and group, then wake in low power.
        wr(`FCC_ADDR_CONTROL, 16'ha000);
        power_mode <= FCC_IDLE;
        settle(4);
        chk_out("power", 16'h0000, analog_power);
        wr(`FCC_ADDR_CONTROL, 16'h8000);
        group_idle_stop <= 1'b1;
        settle(4);
        chk_out("power", 16'h0000, analog_power);
        group_idle_stop <= 1'b0;
        settle(8);
        chk_out("power", 16'h0001, analog_power);
        chk_out("wake", 16'h0001, wake_request);
        power_mode <= FCC_SLEEP;
        comp_raw <= 1'b0;
        settle(8);
        chk_out("wake", 16'h0000, wake_request);
        comp_raw <= 1'b1;
        settle(8);
        chk_out("wake", 16'h0001, wake_request);
        $display("test low power done");
        tally_and_finish();
    end
endmodule : tb_top
